// ---- pidams_top.sv ----
// Notes on behaviour
// RULE1: input low point is 0%, high point 100%; swapped inverts.
// RULE2: type code 2 is unipolar voltage, code 1 is 4-20 mA.
// RULE3: error inside the dead band is ignored.
// RULE4: each start preloads the integrator.
// RULE5: trim limits clamp the output in trim mode only.
// RULE6: integration halts at an output limit.
// RULE7: p term is gain times error; gain 1 gives full scale.
// RULE8: full error for integral time gives full scale; 0 disables.
// RULE9: d term is rate times error change; 0 disables.
// RULE10: staging runs only in staging mode one.
// RULE11: up to three line motors, count from a setting.
// RULE12: start a motor after start delay above start level.
// RULE13: stop a motor after stop delay below stop level.
// RULE14: starting lowers drive speed, stopping raises it.
// RULE15: out of service motors are skipped.
// RULE16: rotation moves the drive connection to the next motor.
// RULE17: swap opens drive, opens next line, closes, restarts.
// RULE18: relays energized from power-up until configured.
// RULE19: selector 5 to 8 is trim, 1 to 4 exclusive.
// RULE20: a due swap waits for output below swap level.
// RULE21: output sums the three terms once per period.
//
// The register offsets and the APB interface to the registers were decided locally.
module pidams_top #(
	parameter int TICK_CYCLES = pidams_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// process signals, same clock
	input wire logic [1:0][11:0] ain_raw,
	input wire logic [10:0] feedback_pct,
	input wire logic [15:0] speed_ref,
	input wire logic drive_run,
	// motor interlock pins, high means out of service
	input wire logic [3:0] motor_out_of_service,
	// drive and contactors
	output logic [15:0] freq_cmd,
	output logic drive_enable,
	output wire pidams_pkg::pidams_relay_t relays
);
	// ****************
	// register file
	// ****************
	logic [31:0] regs_q [pidams_pkg::NREG];
	logic [31:0] prdata_q;
	logic cfg_done_q;
	logic [3:0] idx;
	logic mapped, wr_en;
	assign idx = paddr[5:2];
	assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
		(idx <= pidams_pkg::IDX_STAT2);
	assign wr_en = psel && penable && pwrite && mapped &&
		(idx < pidams_pkg::IDX_STAT);
	assign pready = 1'b1;
	// writes to status words are flagged as errors and dropped
	assign pslverr = psel && penable && (!mapped ||
		(pwrite && idx >= pidams_pkg::IDX_STAT));
	assign prdata = prdata_q;

	logic [3:0] sel;
	logic [1:0] smode, scount;
	logic rot_en, trim, active;
	pidams_pkg::pidams_scale_t sfreq, sdelay;
	logic [15:0] setpt, dead_band, preload, maxf, trim_up, trim_rev;
	logic [15:0] kp, ti, kd, swap_lvl, swap_time;
	assign sel = regs_q[pidams_pkg::IDX_CTRL][pidams_pkg::F_SEL_LSB +: 4];
	assign setpt = regs_q[pidams_pkg::IDX_SETPT][15:0];
	assign dead_band = regs_q[pidams_pkg::IDX_SETPT][pidams_pkg::F_HI_LSB +: 16];
	assign preload = regs_q[pidams_pkg::IDX_PRELOAD][15:0];
	assign maxf = regs_q[pidams_pkg::IDX_PRELOAD][pidams_pkg::F_HI_LSB +: 16];
	assign trim_up = regs_q[pidams_pkg::IDX_TRIM][15:0];
	assign trim_rev = regs_q[pidams_pkg::IDX_TRIM][pidams_pkg::F_HI_LSB +: 16];
	assign kp = regs_q[pidams_pkg::IDX_GAIN][15:0];
	assign ti = regs_q[pidams_pkg::IDX_GAIN][pidams_pkg::F_HI_LSB +: 16];
	assign kd = regs_q[pidams_pkg::IDX_DRATE][15:0];
	assign swap_lvl = regs_q[pidams_pkg::IDX_DRATE][pidams_pkg::F_HI_LSB +: 16];
	assign smode = regs_q[pidams_pkg::IDX_STAGE][pidams_pkg::F_MODE_LSB +: 2];
	assign scount = regs_q[pidams_pkg::IDX_STAGE][pidams_pkg::F_CNT_LSB +: 2];
	assign rot_en = regs_q[pidams_pkg::IDX_STAGE][pidams_pkg::F_ROT_BIT];
	assign sfreq = regs_q[pidams_pkg::IDX_SFREQ];
	assign sdelay = regs_q[pidams_pkg::IDX_SDELAY];
	assign swap_time = regs_q[pidams_pkg::IDX_SWAPT][15:0];
	assign trim = (sel >= pidams_pkg::SEL_FIRST_TRIM) &&
		(sel <= pidams_pkg::SEL_LAST_TRIM); // [RULE19]
	assign active = (sel != 4'h0) && (sel <= pidams_pkg::SEL_LAST_TRIM);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int r = 0; r < pidams_pkg::NREG; r++) begin
				regs_q[r] <= pidams_pkg::RST_VAL[r];
			end
		end else if (wr_en) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b]) begin
					regs_q[idx][8*b +: 8] <= pwdata[8*b +: 8];
				end
			end
		end
	end

	// relays stay energized until staging has been configured once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_done_q <= 1'b0;
		end else if (wr_en && idx == pidams_pkg::IDX_STAGE) begin
			cfg_done_q <= 1'b1; // [RULE18]
		end
	end

	// ****************
	// reference conditioning, one lane per analog input
	// ****************
	logic [1:0][10:0] ain_ref;
	for (genvar ch = 0; ch < 2; ch++) begin : g_ain
		logic signed [17:0] pct, lo, hi, span;
		logic signed [31:0] q;
		logic [1:0] typ;
		pidams_pkg::pidams_scale_t scl;
		assign scl = regs_q[pidams_pkg::IDX_AIN1 + 4'(ch)];
		assign typ = regs_q[pidams_pkg::IDX_CTRL][pidams_pkg::F_TYPE_LSB+2*ch +: 2];
		always_comb begin
			lo = $signed({2'b00, scl.low});
			hi = $signed({2'b00, scl.high});
			// current mode drops the live-zero offset, below 4 mA reads 0%
			if (typ == pidams_pkg::AIN_MA) begin
				if (32'(ain_raw[ch]) < pidams_pkg::ADC_4MA) begin
					pct = 18'sh0;
				end else begin
					pct = 18'((32'(ain_raw[ch]) - pidams_pkg::ADC_4MA) *
						pidams_pkg::PCT_FULL /
						(pidams_pkg::ADC_FULL - pidams_pkg::ADC_4MA)); // [RULE2]
				end
			end else begin
				pct = 18'(32'(ain_raw[ch]) * pidams_pkg::PCT_FULL /
					pidams_pkg::ADC_FULL); // [RULE2]
			end
			span = hi - lo;
			// a negative span inverts the mapping
			if (span == 18'sh0) begin
				q = (pct >= lo) ? pidams_pkg::PCT_FULL : 0;
			end else begin
				q = (32'(pct - lo) * pidams_pkg::PCT_FULL) / 32'(span); // [RULE1]
			end
			if (q < 0) begin
				ain_ref[ch] = 11'h000;
			end else if (q > pidams_pkg::PCT_FULL) begin
				ain_ref[ch] = 11'(pidams_pkg::PCT_FULL);
			end else begin
				ain_ref[ch] = 11'(q);
			end
		end
	end

	// ****************
	// regulator
	// ****************
	logic [10:0] pid_ref;
	logic signed [11:0] err, err_db, err_prev_q;
	logic signed [12:0] de;
	logic [15:0] mag;
	logic signed [47:0] i_acc_q, den, p_t, i_t, d_t, sum, lim_hi, lim_lo;
	logic signed [47:0] comp, maxf_s;
	logic signed [16:0] pid_q;
	logic sat_hi, sat_lo, pid_run, run_prev_q, start_ev, tick;
	logic [31:0] tick_cnt_q;
	logic [15:0] freq_q;
	logic up_fire, dn_fire;
	pidams_pkg::pidams_swap_t sw_st_q;

	always_comb begin
		case (sel)
			4'h2, 4'h6: pid_ref = ain_ref[0];
			4'h3, 4'h7: pid_ref = ain_ref[1];
			4'h1, 4'h4, 4'h5, 4'h8: pid_ref = setpt[10:0];
			default: pid_ref = 11'h000;
		endcase
	end

	assign err = $signed({1'b0, pid_ref}) - $signed({1'b0, feedback_pct});
	assign mag = 16'(err < 0 ? -err : err);
	assign err_db = (mag <= dead_band) ? 12'sh000 : err; // [RULE3]
	assign de = 13'(err_db) - 13'(err_prev_q);
	assign maxf_s = $signed({32'h0, maxf});
	assign den = $signed({32'h0, ti}) * pidams_pkg::ITG_SCALE;
	assign p_t = ($signed({1'b0, kp}) * err_db * maxf_s) /
		pidams_pkg::KP_UNITY; // [RULE7]
	assign i_t = (ti == 16'h0) ? 48'sh0 : i_acc_q / den; // [RULE8]
	assign d_t = ($signed({1'b0, kd}) * de * maxf_s) /
		pidams_pkg::KD_SCALE; // [RULE9]
	assign sum = p_t + i_t + d_t; // [RULE21]
	assign lim_hi = trim ? $signed({32'h0, trim_up}) : maxf_s; // [RULE5]
	assign lim_lo = trim ? -$signed({32'h0, trim_rev}) : 48'sh0; // [RULE5]
	assign sat_hi = sum >= lim_hi;
	assign sat_lo = sum <= lim_lo;
	assign comp = $signed({32'h0, sfreq.low}) - $signed({32'h0, sfreq.high});
	assign pid_run = drive_run && active && (sw_st_q == pidams_pkg::SW_IDLE);
	assign start_ev = pid_run && !run_prev_q;
	assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h0;
		end else if (tick) begin
			tick_cnt_q <= 32'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i_acc_q <= 48'sh0;
			err_prev_q <= 12'sh000;
			pid_q <= 17'sh0;
			run_prev_q <= 1'b0;
		end else begin
			run_prev_q <= pid_run;
			if (start_ev) begin
				i_acc_q <= $signed({32'h0, preload}) * den; // [RULE4]
				err_prev_q <= err_db;
			end else if (pid_run && (up_fire || dn_fire)) begin
				// shift the integrator by the start-stop frequency gap
				i_acc_q <= up_fire ? i_acc_q - comp * den
					: i_acc_q + comp * den; // [RULE14]
			end else if (pid_run && tick) begin
				err_prev_q <= err_db;
				// integrate only when it does not push further into a limit
				if (!(sat_hi && err_db > 0) && !(sat_lo && err_db < 0)) begin
					i_acc_q <= i_acc_q + 48'(err_db) * maxf_s; // [RULE6]
				end
			end
			if (!pid_run) begin
				pid_q <= 17'sh0;
			end else if (tick) begin
				pid_q <= sat_hi ? 17'(lim_hi) : sat_lo ? 17'(lim_lo)
					: 17'(sum); // [RULE21]
			end
		end
	end

	// trim adds onto the speed reference, exclusive replaces it
	logic signed [17:0] trim_sum;
	assign trim_sum = $signed({2'b00, speed_ref}) + 18'(pid_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_q <= 16'h0;
			drive_enable <= 1'b0;
		end else begin
			drive_enable <= drive_run && (sw_st_q == pidams_pkg::SW_IDLE);
			if (!drive_run || sw_st_q != pidams_pkg::SW_IDLE) begin
				freq_q <= 16'h0;
			end else if (trim) begin
				freq_q <= (trim_sum < 0) ? 16'h0 :
					(trim_sum > $signed({2'b00, maxf})) ? maxf
					: 16'(trim_sum);
			end else if (active) begin
				freq_q <= (pid_q < 0) ? 16'h0 : pid_q[15:0];
			end else begin
				freq_q <= speed_ref;
			end
		end
	end
	assign freq_cmd = freq_q;

	// ****************
	// interlock sync and relay drivers, one lane per motor
	// ****************
	logic [3:0] oos, line_q;
	logic [1:0] drv_q, nxt_q, old_q;
	logic drv_closed_q, was_q;
	for (genvar m = 0; m < 4; m++) begin : g_mot
		logic [2:0] s_q;
		logic f_q, d_rly_q, l_rly_q;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s_q <= 3'h0;
				f_q <= 1'b0;
				d_rly_q <= 1'b1;
				l_rly_q <= 1'b1;
			end else begin
				s_q <= {s_q[1:0], motor_out_of_service[m]};
				if (s_q[1] == s_q[2]) begin
					f_q <= s_q[2];
				end
				d_rly_q <= !cfg_done_q ||
					(drv_q == 2'(m) && drv_closed_q); // [RULE18]
				l_rly_q <= !cfg_done_q || line_q[m]; // [RULE18]
			end
		end
		assign oos[m] = f_q;
		assign relays.drive[m] = d_rly_q;
		assign relays.line[m] = l_rly_q;
	end

	// ****************
	// staging
	// ****************
	logic st_en, up_ok, dn_ok, sw_ok, sw_fire;
	logic [1:0] up_idx, dn_idx, sw_idx, cand;
	logic [23:0] up_cnt_q, dn_cnt_q, sw_cnt_q, lim_up, lim_dn, lim_sw;
	assign st_en = (smode == pidams_pkg::STAGE_ON) && drive_run; // [RULE10]
	assign lim_up = 24'(32'(sdelay.low) * pidams_pkg::TICKS_DSEC);
	assign lim_dn = 24'(32'(sdelay.high) * pidams_pkg::TICKS_DSEC);
	assign lim_sw = 24'(32'(swap_time) * pidams_pkg::TICKS_DSEC);

	// search in rotation order after the drive motor, motors 0..count in use
	always_comb begin
		up_ok = 1'b0;
		dn_ok = 1'b0;
		sw_ok = 1'b0;
		up_idx = drv_q;
		dn_idx = drv_q;
		sw_idx = drv_q;
		cand = drv_q;
		for (int k = 3; k >= 1; k--) begin
			cand = drv_q + 2'(k);
			if (cand <= scount && !oos[cand]) begin // [RULE11]
				sw_ok = 1'b1;
				sw_idx = cand;
				if (!line_q[cand]) begin
					up_ok = 1'b1; // [RULE15]
					up_idx = cand;
				end
			end
		end
		for (int k = 1; k <= 3; k++) begin
			cand = drv_q + 2'(k);
			if (line_q[cand]) begin
				dn_ok = 1'b1;
				dn_idx = cand;
			end
		end
	end

	assign up_fire = tick && st_en && up_ok && sw_st_q == pidams_pkg::SW_IDLE &&
		freq_q > sfreq.low && up_cnt_q + 24'h1 >= lim_up; // [RULE12]
	assign dn_fire = tick && st_en && dn_ok && sw_st_q == pidams_pkg::SW_IDLE &&
		freq_q < sfreq.high && dn_cnt_q + 24'h1 >= lim_dn; // [RULE13]
	assign sw_fire = tick && st_en && rot_en && sw_ok && !up_fire && !dn_fire &&
		sw_st_q == pidams_pkg::SW_IDLE && sw_cnt_q + 24'h1 >= lim_sw &&
		pid_q < $signed({1'b0, swap_lvl}); // [RULE20]

	// continuity timers restart whenever the condition breaks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_cnt_q <= 24'h0;
			dn_cnt_q <= 24'h0;
			sw_cnt_q <= 24'h0;
		end else begin
			if (!st_en || freq_q <= sfreq.low || up_fire) begin
				up_cnt_q <= 24'h0; // [RULE12]
			end else if (tick && up_cnt_q < lim_up) begin
				up_cnt_q <= up_cnt_q + 24'h1;
			end
			if (!st_en || freq_q >= sfreq.high || dn_fire) begin
				dn_cnt_q <= 24'h0; // [RULE13]
			end else if (tick && dn_cnt_q < lim_dn) begin
				dn_cnt_q <= dn_cnt_q + 24'h1;
			end
			// the count saturates so a postponed swap fires on the level alone
			if (!st_en || !rot_en || sw_fire) begin
				sw_cnt_q <= 24'h0;
			end else if (tick && sw_cnt_q < lim_sw) begin
				sw_cnt_q <= sw_cnt_q + 24'h1; // [RULE16]
			end
		end
	end

	// each swap step dwells one control period so contactors never overlap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_q <= 4'h0;
			drv_q <= 2'h0;
			nxt_q <= 2'h0;
			old_q <= 2'h0;
			was_q <= 1'b0;
			drv_closed_q <= 1'b1;
			sw_st_q <= pidams_pkg::SW_IDLE;
		end else begin
			line_q <= line_q & ~oos & {4{st_en}}; // [RULE15]
			case (sw_st_q)
				pidams_pkg::SW_IDLE: begin
					if (up_fire) begin
						line_q[up_idx] <= 1'b1; // [RULE12]
					end else if (dn_fire) begin
						line_q[dn_idx] <= 1'b0; // [RULE13]
					end else if (sw_fire) begin
						nxt_q <= sw_idx;
						old_q <= drv_q;
						sw_st_q <= pidams_pkg::SW_STOP; // [RULE16]
					end
				end
				pidams_pkg::SW_STOP: begin
					if (tick) begin
						drv_closed_q <= 1'b0; // [RULE17]
						sw_st_q <= pidams_pkg::SW_LINE_OPEN;
					end
				end
				pidams_pkg::SW_LINE_OPEN: begin
					if (tick) begin
						was_q <= line_q[nxt_q];
						line_q[nxt_q] <= 1'b0; // [RULE17]
						sw_st_q <= pidams_pkg::SW_CLOSE;
					end
				end
				pidams_pkg::SW_CLOSE: begin
					if (tick) begin
						drv_q <= nxt_q;
						drv_closed_q <= 1'b1; // [RULE17]
						sw_st_q <= pidams_pkg::SW_START;
					end
				end
				pidams_pkg::SW_START: begin
					if (tick) begin
						if (was_q && st_en && !oos[old_q]) begin
							line_q[old_q] <= 1'b1; // [RULE17]
						end
						sw_st_q <= pidams_pkg::SW_IDLE;
					end
				end
				default: sw_st_q <= pidams_pkg::SW_IDLE;
			endcase
		end
	end

	// ****************
	// read data, captured in the setup cycle
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (psel && !penable) begin
			if (!mapped) begin
				prdata_q <= 32'h0;
			end else if (idx == pidams_pkg::IDX_STAT) begin
				prdata_q <= {4'h0, cfg_done_q, sw_st_q != pidams_pkg::SW_IDLE,
					drv_q, relays.drive, relays.line, freq_q};
			end else if (idx == pidams_pkg::IDX_STAT2) begin
				prdata_q <= {5'h00, pid_ref, pid_q[15:0]};
			end else begin
				prdata_q <= regs_q[idx];
			end
		end
	end
endmodule : pidams_top

// ---- pidams_pkg.sv ----
package pidams_pkg;
	// ****************
	// register map (word index = paddr[5:2])
	// ****************
	localparam int NREG = 12;
	localparam logic [3:0] IDX_CTRL = 4'h0;
	localparam logic [3:0] IDX_AIN1 = 4'h1;
	localparam logic [3:0] IDX_AIN2 = 4'h2;
	localparam logic [3:0] IDX_SETPT = 4'h3;
	localparam logic [3:0] IDX_PRELOAD = 4'h4;
	localparam logic [3:0] IDX_TRIM = 4'h5;
	localparam logic [3:0] IDX_GAIN = 4'h6;
	localparam logic [3:0] IDX_DRATE = 4'h7;
	localparam logic [3:0] IDX_STAGE = 4'h8;
	localparam logic [3:0] IDX_SFREQ = 4'h9;
	localparam logic [3:0] IDX_SDELAY = 4'ha;
	localparam logic [3:0] IDX_SWAPT = 4'hb;
	localparam logic [3:0] IDX_STAT = 4'hc;
	localparam logic [3:0] IDX_STAT2 = 4'hd;
	localparam logic [31:0] RST_VAL [NREG] = '{
		32'h0000_0000, 32'h03e8_0000, 32'h03e8_0000, 32'h0000_0000,
		32'h0258_0000, 32'h0000_0258, 32'h0014_0064, 32'h0258_0000,
		32'h0000_0000, 32'h00c8_0226, 32'h0032_0032, 32'h0000_0bb8};
	// ****************
	// field positions and codes
	// ****************
	localparam int F_SEL_LSB = 0;
	localparam int F_TYPE_LSB = 4;
	localparam int F_HI_LSB = 16;
	localparam int F_MODE_LSB = 0;
	localparam int F_CNT_LSB = 2;
	localparam int F_ROT_BIT = 4;
	localparam logic [1:0] AIN_MA = 2'h1;
	localparam logic [1:0] AIN_VOLT = 2'h2;
	localparam logic [1:0] STAGE_ON = 2'h1;
	localparam logic [3:0] SEL_LAST_EXCL = 4'h4;
	localparam logic [3:0] SEL_FIRST_TRIM = 4'h5;
	localparam logic [3:0] SEL_LAST_TRIM = 4'h8;
	// ****************
	// scaling and timing
	// ****************
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam int DSEC_MS = 100;
	localparam int TICKS_DSEC = DSEC_MS * 1000 / TICK_US;
	localparam int PCT_FULL = 1000;
	localparam int ADC_FULL = 4095;
	localparam int ADC_4MA = 819;
	localparam int KP_UNITY = 100 * PCT_FULL;
	localparam int ITG_SCALE = PCT_FULL * TICKS_DSEC;
	localparam int KD_SCALE = 1000;
	typedef enum logic [2:0] {
		SW_IDLE = 3'b000,
		SW_STOP = 3'b001,
		SW_LINE_OPEN = 3'b010,
		SW_CLOSE = 3'b011,
		SW_START = 3'b100
	} pidams_swap_t;
	typedef struct packed {
		logic [15:0] high;
		logic [15:0] low;
	} pidams_scale_t;
	typedef struct packed {
		logic [3:0] drive;
		logic [3:0] line;
	} pidams_relay_t;
endpackage : pidams_pkg

// ---- pidams_properties.sv ----
// ****************
// contactor and register bus checker
// ****************
module pidams_checker #(
	parameter int TICK_CYCLES = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// drive side
	input wire logic drive_run,
	input wire logic [3:0] motor_out_of_service,
	input wire logic drive_enable,
	input wire pidams_pkg::pidams_relay_t relays
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SW_WAIT = TICK_CYCLES + 5;
	localparam int SW_LONG = 4 * TICK_CYCLES + 10;
	logic [1:0] cfg_age_q;
	logic [1:0] mode_q;
	logic [3:0] oos_prev_q;
	logic [2:0] oos_age_q;
	logic stage_wr;
	logic bad_addr;
	assign stage_wr = psel && penable && pwrite && paddr == 12'h020;
	assign bad_addr = paddr[11:6] != 6'h0 || paddr[1:0] != 2'h0
		|| paddr[5:2] > 4'hd;
	// age saturates so the relay flops have settled before checks begin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_age_q <= 2'h0;
		end else if (cfg_age_q != 2'h3 && (stage_wr || cfg_age_q != 2'h0)) begin
			cfg_age_q <= cfg_age_q + 2'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 2'h0;
		end else if (stage_wr) begin
			mode_q <= pwdata[1:0];
		end
	end
	// pins are synchronised and filtered inside, so allow them time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oos_prev_q <= 4'h0;
			oos_age_q <= 3'h0;
		end else begin
			oos_prev_q <= motor_out_of_service;
			if (motor_out_of_service != oos_prev_q) begin
				oos_age_q <= 3'h0;
			end else if (oos_age_q != 3'h7) begin
				oos_age_q <= oos_age_q + 3'h1;
			end
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence swap_begin_s;
		drive_run && $past(drive_run) && $fell(drive_enable);
	endsequence
	sequence drive_open_s;
		relays.drive == 4'h0 && !drive_enable;
	endsequence
	sequence drive_back_s;
		$onehot(relays.drive) && drive_enable;
	endsequence
	relays_energized_a: assert property (cfg_age_q == 2'h0 |-> relays == 8'hff)
		else $error("relays dropped early");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("no ready");
	apb_refuse_a: assert property (psel && penable && bad_addr
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	apb_accept_a: assert property (psel && penable && !bad_addr
		&& paddr[5:2] < 4'hc |-> !pslverr)
		else $error("mapped access refused");
	status_ro_a: assert property (psel && penable && pwrite
		&& paddr[5:2] >= 4'hc |-> pslverr)
		else $error("status write not refused");
	no_clash_a: assert property (cfg_age_q == 2'h3 |-> (relays.drive & relays.line) == 4'h0)
		else $error("contactor clash");
	one_drive_a: assert property (cfg_age_q == 2'h3 |-> $onehot0(relays.drive))
		else $error("two drive contactors");
	line_idle_a: assert property ((cfg_age_q == 2'h3 && (mode_q != pidams_pkg::STAGE_ON || !drive_run)) [*3] |-> relays.line == 4'h0)
		else $error("line closed, staging off");
	oos_skip_a: assert property (cfg_age_q == 2'h3 && oos_age_q == 3'h7 |-> (relays.line & motor_out_of_service) == 4'h0)
		else $error("idle motor started");
	run_gate_a: assert property (!drive_run |=> !drive_enable)
		else $error("drive enabled without run");
	swap_steps_a: assert property (swap_begin_s |-> ##[1:SW_WAIT] drive_open_s ##[1:SW_LONG] drive_back_s)
		else $error("swap order");
endmodule : pidams_checker

// ---- pidams_contactor_model.sv ----
// ****************
// motor contactors and interlock switches
// ****************
module pidams_contactor_model (
	// clock
	input wire logic pclk,
	// coils and bench commands
	input wire pidams_pkg::pidams_relay_t relays,
	input wire logic armed,
	input wire logic [3:0] oos_cmd,
	// interlock pins and fault count
	output logic [3:0] motor_out_of_service,
	output int clash_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// interlock switches follow the operator, not the drive
	assign motor_out_of_service = oos_cmd;
	initial clash_cnt = 0;
	// both contactors of one motor closed would short the drive output
	always @(posedge pclk) begin
		if (armed && (relays.drive & relays.line) != 4'h0) begin
			clash_cnt <= clash_cnt + 1;
		end
	end
endmodule : pidams_contactor_model

// ---- pidams_tb_top.sv ----
`define PIDAMS_CHK(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			error_cnt++; \
			$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
		end \
	end
// ****************
// bench top
// ****************
module pidams_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 20;
	localparam int MAXF = int'(pidams_pkg::RST_VAL[4][31:16]);
	typedef struct {
		logic [31:0] ctrl;
		logic [31:0] ain;
		logic [31:0] spt;
		logic [11:0] raw;
		logic [10:0] fb;
		logic [15:0] res;
	} pidams_case_t;
	logic pclk, presetn, psel, penable, pwrite, drive_run, armed;
	logic pready, pslverr, drive_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0][11:0] ain_raw;
	logic [10:0] feedback_pct;
	logic [15:0] speed_ref, freq_cmd;
	logic [3:0] oos_cmd, motor_out_of_service;
	pidams_pkg::pidams_relay_t relays;
	int error_cnt = 0;
	int cmp_count = 0;
	int clash_cnt;
	pidams_case_t tbl [6] = '{
		'{32'h22, 32'h01f4_0000, 32'h0, 12'h800, 11'h0, 16'h012c},
		'{32'h12, 32'h0000_03e8, 32'h0, 12'h333, 11'h0, 16'h012c},
		'{32'h12, 32'h0000_03e8, 32'h0, 12'hfff, 11'h0, 16'h0},
		'{32'h01, 32'h03e8_0000, 32'h0032_00fa, 12'h0, 11'h0dc, 16'h0},
		'{32'h05, 32'h03e8_0000, 32'h03e8, 12'h0, 11'h0, 16'h0064},
		'{32'h05, 32'h03e8_0000, 32'h0, 12'h0, 11'h3e8, 16'hffce}};
	pidams_top #(.TICK_CYCLES(TICK)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ain_raw(ain_raw), .feedback_pct(feedback_pct),
		.speed_ref(speed_ref), .drive_run(drive_run),
		.motor_out_of_service(motor_out_of_service), .freq_cmd(freq_cmd),
		.drive_enable(drive_enable), .relays(relays));
	pidams_contactor_model u_motors (.pclk(pclk), .relays(relays),
		.armed(armed), .oos_cmd(oos_cmd),
		.motor_out_of_service(motor_out_of_service), .clash_cnt(clash_cnt));
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	// regulator output is read from the status word after three ticks
	task automatic pid_out_is(input logic [15:0] exp_v);
		logic [31:0] r;
		logic e;
		repeat (3 * TICK + 4) @(posedge pclk);
		apb(1'b0, 12'h034, 32'h0, r, e);
		`PIDAMS_CHK(r[15:0], exp_v)
	endtask : pid_out_is
	task automatic wait_line(input logic [3:0] exp_v, output int n);
		n = 0;
		while (relays.line !== exp_v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		`PIDAMS_CHK(relays.line, exp_v)
	endtask : wait_line
	task automatic wait_de(input logic v);
		for (int n = 0; n < 3000 && drive_enable !== v; n++) begin
			@(posedge pclk);
		end
	endtask : wait_de
	function automatic logic [15:0] exp_p(input int sp, input int fb,
		input int g);
		int v;
		v = (sp - fb) * g * MAXF / pidams_pkg::KP_UNITY;
		v = v < 0 ? 0 : (v > MAXF ? MAXF : v);
		return v[15:0];
	endfunction : exp_p
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		final_report();
	end
	initial begin
		logic [31:0] r;
		logic e;
		int sp, fb, n;
		{presetn, psel, penable, pwrite, armed} = 5'h0;
		{paddr, pwdata, ain_raw, feedback_pct, oos_cmd} = '0;
		speed_ref = 16'h0100;
		drive_run = 1'b1;
		void'($urandom(32'h8c7b));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < pidams_pkg::NREG; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0, r, e);
			`PIDAMS_CHK(r, pidams_pkg::RST_VAL[i])
		end
		apb(1'b0, 12'h038, 32'h0, r, e);
		`PIDAMS_CHK({e, r}, {1'b1, 32'h0})
		apb(1'b1, 12'h030, 32'h5a5a_5a5a, r, e);
		`PIDAMS_CHK(e, 1'b1)
		`PIDAMS_CHK(relays, 8'hff)
		$display("test registers done");
		wr(12'h018, 32'h0000_0032);
		wr(12'h014, 32'h0032_0064);
		wr(12'h020, 32'h0);
		repeat (4) @(posedge pclk);
		`PIDAMS_CHK(relays.line, 4'h0)
		armed <= 1'b1;
		foreach (tbl[i]) begin
			wr(12'h000, tbl[i].ctrl);
			wr(12'h004, tbl[i].ain);
			wr(12'h00c, tbl[i].spt);
			ain_raw[0] <= tbl[i].raw;
			feedback_pct <= tbl[i].fb;
			pid_out_is(tbl[i].res);
		end
		$display("test scaling done");
		wr(12'h000, 32'h01);
		for (int k = 0; k < 8; k++) begin
			sp = 10 * $urandom_range(0, 100);
			fb = 10 * $urandom_range(0, 100);
			wr(12'h00c, 32'(sp));
			feedback_pct <= 11'(fb);
			ain_raw[1] <= 12'($urandom);
			speed_ref <= 16'($urandom_range(0, 600));
			pid_out_is(exp_p(sp, fb, 50));
		end
		wr(12'h018, 32'h0);
		wr(12'h00c, 32'h3e8);
		feedback_pct <= 11'h0;
		pid_out_is(16'h0);
		$display("test gains done");
		wr(12'h018, 32'h0014_0000);
		wr(12'h010, 32'h0258_00c8);
		wr(12'h00c, 32'h1f4);
		feedback_pct <= 11'h1f4;
		drive_run <= 1'b0;
		repeat (4) @(posedge pclk);
		drive_run <= 1'b1;
		pid_out_is(16'h00c8);
		`PIDAMS_CHK(freq_cmd, 16'h00c8)
		$display("test preload done");
		wr(12'h018, 32'h0000_0064);
		wr(12'h028, 32'h0001_0001);
		wr(12'h020, 32'h05);
		wr(12'h00c, 32'h3e8);
		feedback_pct <= 11'h0;
		wait_line(4'h2, n);
		`PIDAMS_CHK(n > 1900, 1'b1)
		`PIDAMS_CHK(relays.drive, 4'h1)
		feedback_pct <= 11'h3e8;
		wait_line(4'h0, n);
		`PIDAMS_CHK(n > 1900, 1'b1)
		oos_cmd <= 4'h2;
		wr(12'h020, 32'h09);
		feedback_pct <= 11'h0;
		wait_line(4'h4, n);
		feedback_pct <= 11'h3e8;
		wait_line(4'h0, n);
		oos_cmd <= 4'h0;
		$display("test staging done");
		wr(12'h02c, 32'h1);
		wr(12'h020, 32'h15);
		wait_de(1'b0);
		wait_de(1'b1);
		`PIDAMS_CHK(relays.drive, 4'h2)
		apb(1'b0, 12'h030, 32'h0, r, e);
		`PIDAMS_CHK(r[25:24], 2'h1)
		`PIDAMS_CHK(clash_cnt, 0)
		$display("test swap done");
		final_report();
	end
endmodule : pidams_tb_top
bind pidams_top pidams_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .drive_run(drive_run),
	.motor_out_of_service(motor_out_of_service),
	.drive_enable(drive_enable), .relays(relays));
